// >>> verilog/mar_map.vh
// Purpose: Offsets, field positions, reset values and channel numbers for the monitor register bank.
// Assumes: Byte-wide register access through the serial slave's address and data strobes.
// Notes:   Multi-byte registers are stored high byte first at consecutive offsets.
`ifndef MAR_MAP_VH
`define MAR_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define MAR_OFS_MB_HA    8'h00
`define MAR_OFS_MB_LA    8'h02
`define MAR_OFS_MB_HW    8'h04
`define MAR_OFS_MB_LW    8'h06
`define MAR_OFS_MC_HA    8'h08
`define MAR_OFS_MC_LA    8'h0a
`define MAR_OFS_MC_HW    8'h0c
`define MAR_OFS_MC_LW    8'h0e
`define MAR_OFS_RES_T    8'h10
`define MAR_OFS_RES_S    8'h12
`define MAR_OFS_RES_A    8'h14
`define MAR_OFS_RES_B    8'h16
`define MAR_OFS_RES_C    8'h18
`define MAR_OFS_STAT     8'h1a
`define MAR_OFS_RDY      8'h1b
`define MAR_OFS_ALM0     8'h1c
`define MAR_OFS_ALM1     8'h1d
`define MAR_OFS_WRN0     8'h1e
`define MAR_OFS_WRN1     8'h1f
`define MAR_OFS_SPARE    8'h20
`define MAR_OFS_PWE      8'h21
`define MAR_OFS_TBL      8'h25
`define MAR_OFS_MODE     8'h26
`define MAR_OFS_TIDX     8'h27
`define MAR_OFS_IEN      8'h28
`define MAR_OFS_RA       8'h29
`define MAR_OFS_RB       8'h2a

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MAR_RST_HI       16'h0fff
`define MAR_RST_LO       16'h0000
`define MAR_RST_RES      16'h0000
`define MAR_RST_ALM0     8'h10
`define MAR_RST_WRN      8'h00
`define MAR_RST_PWE      32'h000fffff
`define MAR_RST_TBL      8'h00
`define MAR_RST_MODE     8'h03
`define MAR_RST_TIDX     8'h00
`define MAR_RST_IEN      8'hf8
`define MAR_RST_RSET     8'hff

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MAR_MODE_TEN     0
`define MAR_MODE_AEN     1
`define MAR_ST_RHIZ      7
`define MAR_ST_FIRST_BUFFERED_OUTPUT      2
`define MAR_ST_SECOND_BUFFERED_OUTPUT      1
`define MAR_ST_RDYB      0
`define MAR_ALM1_MINT    5

// ----------------------------------------------------------------------------
// Channel numbering
// ----------------------------------------------------------------------------
`define MAR_CH_T         0
`define MAR_CH_S         1
`define MAR_CH_A         2
`define MAR_CH_B         3
`define MAR_CH_C         4

`endif

// >>> verilog/mar_regs.v
// Purpose: Register bank of the monitoring device: limits, results, flags, passwords, modes.
// Assumes: A serial slave outside presents byte writes, byte read addresses and Stop pulses.
// Notes:   Limits of temperature, supply and monitor a are inputs; lookup tables are external.
`timescale 1ns/1ns
`include "mar_map.vh"

// Function
// - High alarm follows measurement versus high limit.
// - Low alarm follows measurement versus low limit.
// - High warning follows measurement versus high limit.
// - Low warning follows measurement versus low limit.
// - Temperature result signed, read-only, resets zero.
// - Supply and monitor results read-only, reset zero.
// - High-impedance status bit, resets to one.
// - Status mirrors first buffered output level.
// - Status mirrors second buffered output level.
// - Ready-bar reads one below power-on trip.
// - One conversion-ready flag per channel.
// - Low supply trip forces supply low flags.
// - Maskable interrupt bit from enabled alarms.
// - Two alarm flag registers, first resets 10h.
// - Two warning flag registers, reset zero.
// - Two password levels via write-only entry.
// - Table select register chooses upper table.
// - Recall enable bit gates lookup recall.
// - Manual resistor values applied at Stop.
// - Auto index bit gates index updates.
// - Recalled values load both resistors together.
// - Index register addresses both lookup tables.
// - Resistor registers update on temperature completion.
// - Interrupt enable register defaults F8h.
module mar_regs #(
    parameter [31:0] USER_PW  = 32'h00000001,
    parameter [31:0] ADMIN_PW = 32'h00000002
) (
    input  wire        ref_clk,
    input  wire        sys_rst,
    input  wire        wr_stb,
    input  wire [7:0]  wr_addr,
    input  wire [7:0]  wr_data,
    input  wire [7:0]  rd_addr,
    output reg  [7:0]  rd_data_r,
    input  wire        stop_stb,
    input  wire        conv_done,
    input  wire [2:0]  conv_ch,
    input  wire [15:0] conv_value,
    input  wire [7:0]  calc_index,
    input  wire [15:0] low_ch_limits_ha,
    input  wire [15:0] low_ch_limits_la,
    input  wire [15:0] low_ch_limits_hw,
    input  wire [15:0] low_ch_limits_lw,
    input  wire [7:0]  lut_a_data,
    input  wire [7:0]  lut_b_data,
    input  wire        supply_low_pin,
    input  wire        res_hiz_pin,
    input  wire        first_buffered_output_level_pin,
    input  wire        second_buffered_output_level_pin,
    output reg  [7:0]  lut_addr_r,
    output reg  [7:0]  resistor_a_setting_r,
    output reg  [7:0]  resistor_b_setting_r,
    output reg  [7:0]  memory_table_select_r,
    output reg         user_password_level_r,
    output reg         admin_password_level_r,
    output reg         mint_r
);

// ----------------------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------------------
reg  [3:0] sync1_r;
reg  [3:0] sync2_r;
always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
        sync1_r <= 4'h9;
        sync2_r <= 4'h9;
    end else begin
        sync1_r <= {res_hiz_pin, first_buffered_output_level_pin, second_buffered_output_level_pin, supply_low_pin};
        sync2_r <= sync1_r;
    end
end
// Logic reads only the second stage; the first may still be settling.
wire supply_low = sync2_r[0];

// ----------------------------------------------------------------------------
// Storage
// ----------------------------------------------------------------------------
reg  [15:0] lim_r [0:7];
reg  [15:0] res_r [0:4];
reg  [4:0]  rdy_r;
reg  [4:0]  ah_r;
reg  [4:0]  al_r;
reg  [4:0]  wh_r;
reg  [4:0]  wl_r;
reg  [31:0] pwe_r;
reg  [7:0]  spare_r;
reg  [7:0]  mode_r;
reg  [7:0]  tidx_r;
reg  [7:0]  ien_r;
reg  [7:0]  man_a_r;
reg  [7:0]  man_b_r;
reg         man_pend_r;
reg         recall_pend_r;
reg         recall_wait_r;
integer     i;

wire lookup_recall_enable = mode_r[`MAR_MODE_TEN];
wire auto_index_enable = mode_r[`MAR_MODE_AEN];
wire pw2 = (pwe_r == ADMIN_PW);
wire pw1 = (pwe_r == USER_PW) | pw2;

// ----------------------------------------------------------------------------
// Helper functions
// ----------------------------------------------------------------------------
// Byte lane of a two-byte register: even offset is the high byte.
function [15:0] put_byte;
    input [15:0] old;
    input        lo;
    input [7:0]  b;
    begin
        put_byte = lo ? {old[15:8], b} : {b, old[7:0]};
    end
endfunction

// Unsigned compares; temperature is compared signed.
function gt;
    input [15:0] a;
    input [15:0] b;
    input        sgn;
    begin
        gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
    end
endfunction

// Read side of a two-byte register, same lane order as put_byte.
function [7:0] get_byte;
    input [15:0] w;
    input        lo;
    begin
        get_byte = lo ? w[7:0] : w[15:8];
    end
endfunction

// Channel vectors count from temperature at bit 0; the bytes the host sees
// carry temperature in bit 7, so the two orders are swapped here.
function [4:0] rev5;
    input [4:0] v;
    begin
        rev5 = {v[0], v[1], v[2], v[3], v[4]};
    end
endfunction

// ----------------------------------------------------------------------------
// Channel limit select
// ----------------------------------------------------------------------------
// Limits for a channel: external for the first three, local for b and c.
reg [15:0] c_ha;
reg [15:0] c_la;
reg [15:0] c_hw;
reg [15:0] c_lw;
always @* begin
    c_ha = low_ch_limits_ha;
    c_la = low_ch_limits_la;
    c_hw = low_ch_limits_hw;
    c_lw = low_ch_limits_lw;
    if (conv_ch == `MAR_CH_B) begin
        c_ha = lim_r[0];
        c_la = lim_r[1];
        c_hw = lim_r[2];
        c_lw = lim_r[3];
    end else if (conv_ch == `MAR_CH_C) begin
        c_ha = lim_r[4];
        c_la = lim_r[5];
        c_hw = lim_r[6];
        c_lw = lim_r[7];
    end
end

wire sg = (conv_ch == `MAR_CH_T);
wire cv = conv_done & (conv_ch <= `MAR_CH_C);
wire [4:0] chm = 5'h01 << conv_ch;
wire limit_wr = wr_stb & pw2 & (wr_addr < `MAR_OFS_RES_T);

// ----------------------------------------------------------------------------
// Limits, results and flags
// ----------------------------------------------------------------------------
always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
        for (i = 0; i < 8; i = i + 1) begin
            lim_r[i] <= i[0] ? `MAR_RST_LO : `MAR_RST_HI;
        end
        for (i = 0; i < 5; i = i + 1) begin
            res_r[i] <= `MAR_RST_RES;
        end
        rdy_r <= 5'h00;
        ah_r  <= 5'h00;
        al_r  <= 5'h02;
        wh_r  <= 5'h00;
        wl_r  <= 5'h00;
    end else begin
        // Limits need the admin level; reading them is open to everyone.
        if (limit_wr) begin
            lim_r[wr_addr[3:1]] <= put_byte(lim_r[wr_addr[3:1]], wr_addr[0], wr_data);
        end
        if (cv) begin
            res_r[conv_ch] <= conv_value;
            rdy_r <= rdy_r | chm;
            if (gt(conv_value, c_ha, sg)) ah_r <= ah_r | chm;
            else if (gt(c_ha, conv_value, sg)) ah_r <= ah_r & ~chm;
            if (gt(c_la, conv_value, sg)) al_r <= al_r | chm;
            else if (gt(conv_value, c_la, sg)) al_r <= al_r & ~chm;
            if (gt(conv_value, c_hw, sg)) wh_r <= wh_r | chm;
            else if (gt(c_hw, conv_value, sg)) wh_r <= wh_r & ~chm;
            if (gt(c_lw, conv_value, sg)) wl_r <= wl_r | chm;
            else if (gt(conv_value, c_lw, sg)) wl_r <= wl_r & ~chm;
        end
        // The trip level outranks any measurement taken in the same cycle.
        if (supply_low) begin
            al_r[`MAR_CH_S] <= 1'b1;
            wl_r[`MAR_CH_S] <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------------------
// Control registers, passwords and resistor path
// ----------------------------------------------------------------------------
wire temp_done = cv & (conv_ch == `MAR_CH_T);
// A resistor byte that lands with the Stop keeps its request for the next Stop.
wire man_wr    = wr_stb & pw2 & ~lookup_recall_enable & ((wr_addr == `MAR_OFS_RA) | (wr_addr == `MAR_OFS_RB));
always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
        pwe_r         <= `MAR_RST_PWE;
        spare_r       <= `MAR_RST_TBL;
        memory_table_select_r <= `MAR_RST_TBL;
        mode_r        <= `MAR_RST_MODE;
        tidx_r        <= `MAR_RST_TIDX;
        ien_r         <= `MAR_RST_IEN;
        man_a_r       <= `MAR_RST_RSET;
        man_b_r       <= `MAR_RST_RSET;
        man_pend_r    <= 1'b0;
        recall_pend_r <= 1'b0;
        recall_wait_r <= 1'b0;
        lut_addr_r    <= `MAR_RST_TIDX;
        resistor_a_setting_r <= `MAR_RST_RSET;
        resistor_b_setting_r <= `MAR_RST_RSET;
    end else begin
        // Write-only bytes are stored here but never reach the read port.
        if (wr_stb) begin
            case (wr_addr)
                `MAR_OFS_SPARE: spare_r <= wr_data;
                `MAR_OFS_PWE:   pwe_r[31:24] <= wr_data;
                8'h22:          pwe_r[23:16] <= wr_data;
                8'h23:          pwe_r[15:8]  <= wr_data;
                8'h24:          pwe_r[7:0]   <= wr_data;
                `MAR_OFS_TBL:   memory_table_select_r <= wr_data;
                `MAR_OFS_MODE:  if (pw2) mode_r <= wr_data;
                `MAR_OFS_TIDX:  if (pw2 && !auto_index_enable) tidx_r <= wr_data;
                `MAR_OFS_IEN:   if (pw2) ien_r <= wr_data;
                `MAR_OFS_RA:    if (pw2 && !lookup_recall_enable) begin
                    man_a_r    <= wr_data;
                    man_pend_r <= 1'b1;
                end
                `MAR_OFS_RB:    if (pw2 && !lookup_recall_enable) begin
                    man_b_r    <= wr_data;
                    man_pend_r <= 1'b1;
                end
                default: ;
            endcase
        end
        // A written index is used from the next temperature completion.
        if (temp_done && auto_index_enable) begin
            tidx_r <= calc_index;
        end
        lut_addr_r <= tidx_r;
        // Recall waits two cycles: one for the new index to reach lut_addr_r,
        // one for the tables to answer that address.
        recall_wait_r <= temp_done & lookup_recall_enable;
        recall_pend_r <= recall_wait_r;
        if (recall_pend_r && lookup_recall_enable) begin
            resistor_a_setting_r <= lut_a_data;
            resistor_b_setting_r <= lut_b_data;
        end else if (stop_stb && man_pend_r && !lookup_recall_enable) begin
            resistor_a_setting_r <= man_a_r;
            resistor_b_setting_r <= man_b_r;
            man_pend_r <= man_wr;
        end
    end
end

// ----------------------------------------------------------------------------
// Status, interrupt and read port
// ----------------------------------------------------------------------------
// Enable bits run temperature first from bit 7, like the flag bytes.
wire [4:0] enabled = (ah_r | al_r) & rev5(ien_r[7:3]);
wire [7:0] st_byte = {
    sync2_r[3],
    4'h0,
    sync2_r[2],
    sync2_r[1],
    supply_low
};
wire [7:0] alm0 = {
    ah_r[`MAR_CH_T], al_r[`MAR_CH_T],
    ah_r[`MAR_CH_S], al_r[`MAR_CH_S],
    ah_r[`MAR_CH_A], al_r[`MAR_CH_A],
    ah_r[`MAR_CH_B], al_r[`MAR_CH_B]
};
wire [7:0] alm1 = {
    ah_r[`MAR_CH_C], al_r[`MAR_CH_C],
    mint_r,
    5'h00
};
wire [7:0] wrn0 = {
    wh_r[`MAR_CH_T], wl_r[`MAR_CH_T],
    wh_r[`MAR_CH_S], wl_r[`MAR_CH_S],
    wh_r[`MAR_CH_A], wl_r[`MAR_CH_A],
    wh_r[`MAR_CH_B], wl_r[`MAR_CH_B]
};
wire [7:0] wrn1 = {
    wh_r[`MAR_CH_C], wl_r[`MAR_CH_C],
    6'h00
};

// ----------------------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------------------
// Protected bytes read as zero without the admin level, never as stale data.
reg [7:0] rd_nxt;
always @* begin
    rd_nxt = 8'h00;
    if (rd_addr < `MAR_OFS_RES_T) begin
        rd_nxt = get_byte(lim_r[rd_addr[3:1]], rd_addr[0]);
    end else if (rd_addr < `MAR_OFS_STAT) begin
        rd_nxt = get_byte(res_r[rd_addr[3:1]], rd_addr[0]);
    end else begin
        case (rd_addr)
            `MAR_OFS_STAT: rd_nxt = st_byte;
            `MAR_OFS_RDY:  rd_nxt = {rev5(rdy_r), 3'h0};
            `MAR_OFS_ALM0: rd_nxt = alm0;
            `MAR_OFS_ALM1: rd_nxt = alm1;
            `MAR_OFS_WRN0: rd_nxt = wrn0;
            `MAR_OFS_WRN1: rd_nxt = wrn1;
            `MAR_OFS_TBL:  rd_nxt = memory_table_select_r;
            `MAR_OFS_MODE: rd_nxt = pw2 ? mode_r : 8'h00;
            `MAR_OFS_TIDX: rd_nxt = pw2 ? tidx_r : 8'h00;
            `MAR_OFS_IEN:  rd_nxt = pw2 ? ien_r : 8'h00;
            `MAR_OFS_RA:   rd_nxt = pw2 ? resistor_a_setting_r : 8'h00;
            `MAR_OFS_RB:   rd_nxt = pw2 ? resistor_b_setting_r : 8'h00;
            default:       rd_nxt = 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------------------
// Output registers
// ----------------------------------------------------------------------------
// Levels leave through flops so the host never sees a decode glitch.
// The read byte answers the address of the previous edge.
always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
        rd_data_r <= 8'h00;
        mint_r    <= 1'b0;
        user_password_level_r  <= 1'b0;
        admin_password_level_r <= 1'b0;
    end else begin
        rd_data_r <= rd_nxt;
        mint_r    <= |enabled;
        user_password_level_r  <= pw1;
        admin_password_level_r <= pw2;
    end
end

endmodule // mar_regs

// >>> testbench/mar_regs_properties.sv
// Purpose: Port-level checks of the monitor register bank.
// Assumes: Reads answer one edge after rd_addr; status pins pass two sync flops.
// Notes:   Recall timing is given one edge of slack either way.
`timescale 1ns/1ns
module mar_regs_properties (
    input wire       ref_clk,
    input wire       sys_rst,
    input wire       wr_stb,
    input wire [7:0] wr_addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_addr,
    input wire [7:0] rd_data_r,
    input wire       stop_stb,
    input wire       conv_done,
    input wire       first_buffered_output_level_pin,
    input wire       second_buffered_output_level_pin,
    input wire [7:0] resistor_a_setting_r,
    input wire [7:0] memory_table_select_r,
    input wire       admin_password_level_r
);
    // --------------------
    // Checks
    // --------------------
    wire pw_last = wr_stb && wr_addr == 8'h24;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    AST_TBL_WRITE: assert property (
        wr_stb && wr_addr == 8'h25 |=> memory_table_select_r == $past(wr_data))
        else $error("table select did not take the written byte");
    AST_TBL_HOLD: assert property (
        !(wr_stb && wr_addr == 8'h25) |=> $stable(memory_table_select_r))
        else $error("table select changed without a write");
    AST_RES_CAUSE: assert property (
        !$stable(resistor_a_setting_r) |-> $past(stop_stb) || $past(stop_stb, 2)
        || $past(conv_done, 2) || $past(conv_done, 3) || $past(conv_done, 4))
        else $error("resistor setting changed without stop or conversion");
    AST_PWE_READ: assert property (
        rd_addr >= 8'h20 && rd_addr <= 8'h24 |=> rd_data_r == 8'h00)
        else $error("write-only byte read back nonzero");
    AST_ADMIN_RISE: assert property (
        $rose(admin_password_level_r) |-> $past(pw_last) || $past(pw_last, 2))
        else $error("admin level rose without a password byte");
    AST_STAT_RSVD: assert property (
        rd_addr == 8'h1a |=> rd_data_r[6:3] == 4'h0)
        else $error("reserved status bits nonzero");
    AST_FIRST_BUFFERED_OUTPUT_MIRROR: assert property (
        (first_buffered_output_level_pin && rd_addr == 8'h1a) [*4] |=> rd_data_r[2])
        else $error("first output level not mirrored");
    AST_SECOND_BUFFERED_OUTPUT_MIRROR: assert property (
        (!second_buffered_output_level_pin && rd_addr == 8'h1a) [*4] |=> !rd_data_r[1])
        else $error("second output level not mirrored");
endmodule // mar_regs_properties

bind mar_regs mar_regs_properties chk_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .wr_stb(wr_stb), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data_r(rd_data_r), .stop_stb(stop_stb),
    .conv_done(conv_done), .first_buffered_output_level_pin(first_buffered_output_level_pin),
    .second_buffered_output_level_pin(second_buffered_output_level_pin), .resistor_a_setting_r(resistor_a_setting_r),
    .memory_table_select_r(memory_table_select_r),
    .admin_password_level_r(admin_password_level_r)
);

// >>> testbench/mar_host_model.sv
// Purpose: Serial host seen as byte strobes: writes, reads and Stop.
// Assumes: Requests launch just after a rising edge by non-blocking assignment.
// Notes:   Released data lines show the inverse so a late sample cannot pass.
`timescale 1ns/1ns
module mar_host_model (
    input  wire       ref_clk,
    input  wire [7:0] rd_data_r,
    output reg        wr_stb,
    output reg  [7:0] wr_addr,
    output reg  [7:0] wr_data,
    output reg  [7:0] rd_addr,
    output reg        stop_stb
);
    // --------------------
    // Bus cycles
    // --------------------
    initial begin
        wr_stb = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rd_addr = 8'h00;
        stop_stb = 1'b0;
    end
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            wr_stb <= 1'b1;
            wr_addr <= a;
            wr_data <= d;
            @(posedge ref_clk);
            wr_stb <= 1'b0;
            wr_addr <= ~a;
            wr_data <= ~d;
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge ref_clk);
            rd_addr <= a;
            @(posedge ref_clk);
            #1 d = rd_data_r;
        end
    endtask
    task stop;
        begin
            @(posedge ref_clk);
            stop_stb <= 1'b1;
            @(posedge ref_clk);
            stop_stb <= 1'b0;
        end
    endtask
endmodule // mar_host_model

// >>> testbench/tb.sv
// Purpose: Self-checking bench of the monitor register bank.
// Assumes: Lookup tables are modelled as fixed functions of the lookup address.
// Notes:   Limits of the first three channels come from the bench: low alarm from a bench register, the rest constant.
`timescale 1ns/1ns
module tb;
    localparam [31:0] PW = 32'h00000002;
    reg         ref_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         conv_done = 1'b0;
    reg  [2:0]  conv_ch = 3'h0;
    reg  [15:0] conv_value = 16'h0000;
    reg  [15:0] lim_la = 16'h0000;
    reg         supply_low_pin = 1'b1;
    reg         second_buffered_output_level_pin = 1'b0;
    reg         first_buffered_output_level_pin = 1'b1;
    wire        wr_stb, stop_stb, admin_lvl, user_lvl, mint_r;
    wire [7:0]  wr_addr, wr_data, rd_addr, rd_data_r, lut_addr_r, res_a, res_b, tbl;
    wire [7:0]  lut_a = lut_addr_r ^ 8'h3c;
    wire [7:0]  lut_b = ~lut_addr_r;
    integer     mismatches = 0;
    integer     comparisons = 0;
    reg  [7:0]  rb, i;
    reg  [79:0] mv = {16'h0900, 16'h0700, 16'h0050, 16'h0150, 16'h0400};
    reg  [19:0] ex = {4'ha, 4'h2, 4'h5, 4'h1, 4'h0};
    always #20 ref_clk = ~ref_clk;
    mar_host_model host_u (.ref_clk(ref_clk), .rd_data_r(rd_data_r), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .stop_stb(stop_stb));
    mar_regs #(.ADMIN_PW(PW)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_stb(wr_stb),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data_r(rd_data_r),
        .stop_stb(stop_stb), .conv_done(conv_done), .conv_ch(conv_ch),
        .conv_value(conv_value), .calc_index(8'h12), .low_ch_limits_ha(16'hffff),
        .low_ch_limits_la(lim_la), .low_ch_limits_hw(16'hffff),
        .low_ch_limits_lw(16'h0200), .lut_a_data(lut_a), .lut_b_data(lut_b),
        .supply_low_pin(supply_low_pin), .res_hiz_pin(1'b1), .first_buffered_output_level_pin(first_buffered_output_level_pin),
        .second_buffered_output_level_pin(second_buffered_output_level_pin), .lut_addr_r(lut_addr_r),
        .resistor_a_setting_r(res_a), .resistor_b_setting_r(res_b),
        .memory_table_select_r(tbl), .user_password_level_r(user_lvl),
        .admin_password_level_r(admin_lvl), .mint_r(mint_r));
    // --------------------
    // Shared tasks
    // --------------------
    task chk(input [8*8-1:0] n, input [7:0] e, input [7:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task rdc(input [8*8-1:0] n, input [7:0] a, input [7:0] e);
        begin
            host_u.rd(a, rb);
            chk(n, e, rb);
        end
    endtask
    task conv(input [2:0] c, input [15:0] v);
        begin
            @(posedge ref_clk);
            conv_done <= 1'b1;
            conv_ch <= c;
            conv_value <= v;
            @(posedge ref_clk);
            conv_done <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // --------------------
    // Scenarios
    // --------------------
    task t_reset;
        begin
            rdc("status", 8'h1a, 8'h85);
            repeat (4) @(posedge ref_clk);
            rdc("alarm_flags_first", 8'h1c, 8'h10);
            rdc("warn1", 8'h1f, 8'h00);
            rdc("ready", 8'h1b, 8'h00);
            rdc("res_c", 8'h19, 8'h00);
            rdc("mode", 8'h26, 8'h00);
            rdc("table", 8'h25, 8'h00);
            supply_low_pin <= 1'b0;
        end
    endtask
    task t_password;
        begin
            host_u.wr(8'h25, 8'h01);
            rdc("table", 8'h25, 8'h01);
            chk("admin", 8'h00, {7'h00, admin_lvl});
            chk("user", 8'h00, {7'h00, user_lvl});
            for (i = 0; i < 4; i = i + 1)
                host_u.wr(8'h21 + i, PW[31 - 8 * i -: 8]);
            repeat (2) @(posedge ref_clk);
            chk("admin", 8'h01, {7'h00, admin_lvl});
            chk("user", 8'h01, {7'h00, user_lvl});
            rdc("pwe", 8'h21, 8'h00);
            rdc("mode", 8'h26, 8'h03);
            rdc("ien", 8'h28, 8'hf8);
            rdc("status", 8'h1a, 8'h84);
            @(posedge ref_clk);
            first_buffered_output_level_pin <= 1'b0;
            second_buffered_output_level_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            rdc("status", 8'h1a, 8'h82);
        end
    endtask
    task t_flags;
        begin
            rdc("warn0", 8'h1e, 8'h10);
            lim_la <= 16'h0100;
            conv(3'h1, 16'h1000);
            conv(3'h2, 16'h0300);
            rdc("alarm_flags_first", 8'h1c, 8'h00);
            rdc("ready", 8'h1b, 8'h60);
            for (i = 0; i < 8; i = i + 2)
                host_u.wr(i, 8'h08 - i);
            host_u.wr(8'h02, 8'h01);
            for (i = 0; i < 5; i = i + 1) begin
                conv(3'h3, mv[79 - 16 * i -: 16]);
                rdc("alarm_flags_first", 8'h1c, {6'h00, ex[19 - 4 * i -: 2]});
                rdc("warn0", 8'h1e, {6'h00, ex[17 - 4 * i -: 2]});
            end
            host_u.wr(8'h16, 8'h55);
            rdc("res_b", 8'h16, 8'h04);
            conv(3'h4, 16'hfff0);
            rdc("alarm_flags_second", 8'h1d, 8'ha0);
            chk("mint", 8'h01, {7'h00, mint_r});
            host_u.wr(8'h28, 8'hf0);
            rdc("alarm_flags_second", 8'h1d, 8'h80);
            conv(3'h4, 16'h0100);
            rdc("alarm_flags_second", 8'h1d, 8'h00);
            conv(3'h0, 16'hff00);
            rdc("alarm_flags_first", 8'h1c, 8'h40);
            chk("mint", 8'h01, {7'h00, mint_r});
            host_u.wr(8'h10, 8'h12);
            rdc("temp", 8'h10, 8'hff);
            rdc("ready", 8'h1b, 8'hf8);
        end
    endtask
    task t_recall;
        begin
            chk("res_a", 8'h2e, res_a);
            chk("res_b", 8'hed, res_b);
            host_u.wr(8'h26, 8'h01);
            host_u.wr(8'h27, 8'h05);
            rdc("index", 8'h27, 8'h05);
            conv(3'h0, 16'h0300);
            chk("res_a", 8'h39, res_a);
            chk("res_b", 8'hfa, res_b);
            host_u.wr(8'h26, 8'h00);
            host_u.wr(8'h29, 8'h11);
            host_u.wr(8'h2a, 8'h22);
            conv(3'h0, 16'h0300);
            chk("res_a", 8'h39, res_a);
            host_u.stop;
            repeat (2) @(posedge ref_clk);
            chk("res_a", 8'h11, res_a);
            chk("res_b", 8'h22, res_b);
        end
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_reset;
        t_password;
        t_flags;
        t_recall;
        tally_and_finish;
    end
    initial begin
        #(40 * 5000);
        mismatches = mismatches + 1;
        tally_and_finish;
    end
endmodule // tb
